// ---- ilbt_pkg.sv ----
/*
 * Shared constants, mode type and decode functions for the inverting
 * latched bus transceiver.
 * Assumes a single 40 MHz clock domain and APB register access.
 */
package ilbt_pkg;

   localparam int DATA_W = 9;
   localparam int ADDR_W = 12;
   localparam int APB_W = 32;
   localparam int CNT_W = 16;
   localparam int DIR_FWD = 0;
   localparam int DIR_REV = 1;
   localparam int DIR_N = 2;

   // register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
   localparam logic [ADDR_W-1:0] FWD_OFS = 12'h004;
   localparam logic [ADDR_W-1:0] REV_OFS = 12'h008;
   localparam logic [ADDR_W-1:0] MODE_OFS = 12'h00C;
   localparam logic [ADDR_W-1:0] CAPT_OFS = 12'h010;

   // control register fields
   localparam int CTRL_SW_EN_BIT = 0;
   localparam int CTRL_SEL_FIRST_BIT = 1;
   localparam int CTRL_SEL_SECOND_BIT = 2;
   localparam int CTRL_CNT_CLR_BIT = 3;
   localparam int CTRL_W = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

   // mode status fields
   localparam int MODE_SEL_FIRST_BIT = 0;
   localparam int MODE_SEL_SECOND_BIT = 1;
   localparam int MODE_FWD_LSB = 2;
   localparam int MODE_REV_LSB = 4;
   localparam int MODE_BP_EN_BIT = 6;
   localparam int MODE_LOC_EN_BIT = 7;
   localparam int MODE_SW_EN_BIT = 8;
   localparam int CAPT_REV_LSB = 16;

   localparam logic [DATA_W-1:0] DATA_RESET = 9'h000;
   localparam logic [APB_W-1:0] APB_ZERO = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

   typedef enum logic [1:0] {
      ILBT_THRU  = 2'b00,
      ILBT_LATCH = 2'b01,
      ILBT_REG   = 2'b11
   } ilbt_mode_t;

   function automatic ilbt_mode_t ilbt_fwd_mode(input logic sel_first, input logic sel_second);
      if (sel_second) begin
         ilbt_fwd_mode = ILBT_REG;
      end else if (sel_first) begin
         ilbt_fwd_mode = ILBT_THRU;
      end else begin
         ilbt_fwd_mode = ILBT_LATCH;
      end
   endfunction

   function automatic ilbt_mode_t ilbt_rev_mode(input logic sel_first, input logic sel_second);
      if (sel_first == sel_second) begin
         ilbt_rev_mode = ILBT_LATCH;
      end else if (sel_second) begin
         ilbt_rev_mode = ILBT_REG;
      end else begin
         ilbt_rev_mode = ILBT_THRU;
      end
   endfunction

endpackage

// ---- ilbt_path_if.sv ----
/*
 * Carrier between the transceiver top and one direction's storage path.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface ilbt_path_if import ilbt_pkg::*; ();
   logic [DATA_W-1:0] data_in;
   logic lcle;
   ilbt_mode_t mode;
   logic [DATA_W-1:0] stored;
   logic [DATA_W-1:0] result;
   logic capture;

   modport ctrl (output data_in, lcle, mode, input stored, result, capture);
   modport path (input data_in, lcle, mode, output stored, result, capture);
endinterface

// ---- ilbt_path.sv ----
/*
 * One direction's data path: pass-through, transparent-low latch or
 * rising-edge register, always inverting.
 * Assumes inputs synchronous to clock_i; the top feeds them in unregistered.
 */
`timescale 1ns/1ps
module ilbt_path
   import ilbt_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // direction carrier
   ilbt_path_if.path pif
);

   logic lc_prev_q;
   logic [DATA_W-1:0] in_prev_q;
   logic [DATA_W-1:0] store_q;
   logic edge_w;
   logic transparent_w;

   assign edge_w = pif.lcle & ~lc_prev_q;
   assign transparent_w = (pif.mode == ILBT_LATCH) & ~pif.lcle;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         // track the pin so a level held through reset gives no false rise
         lc_prev_q <= pif.lcle;
         in_prev_q <= DATA_RESET;
      end else begin
         lc_prev_q <= pif.lcle;
         in_prev_q <= pif.data_in;
      end
   end

   // storage runs whatever the output enables say
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         store_q <= DATA_RESET;
      end else begin
         case (pif.mode)
            ILBT_LATCH: begin
               if (!pif.lcle) begin
                  store_q <= pif.data_in;
               end
            end
            ILBT_REG: begin
               if (edge_w) begin
                  store_q <= in_prev_q;
               end
            end
            default: begin
               store_q <= store_q;
            end
         endcase
      end
   end

   assign pif.result = ~((pif.mode == ILBT_THRU || transparent_w) ? pif.data_in : store_q);
   assign pif.stored = store_q;
   assign pif.capture = edge_w & (pif.mode != ILBT_THRU);

endmodule

// ---- ilbt_top.sv ----
/*
 * Nine-bit inverting transceiver between a three-state local port and an
 * open-collector backplane port, with an APB window on its state.
 * Assumes all pins synchronous to clock_i; the bench resolves the
 * backplane wire from the enables, a released line reading high.
 */
// Behaviour
// - nine bits each with local and backplane pin, both directions
// - forward: thru if first high second low, register if second high, else latch
// - reverse: register if 0/1, latch if selects equal, thru if 1/0
// - forward latch transparent while forward enable low
// - forward latch keeps level just before enable rises
// - forward latch holds while enable high
// - forward register stores on forward enable rising edge
// - reverse latch transparent while reverse enable low
// - reverse latch keeps level just before enable rises
// - reverse latch holds while enable high
// - reverse register stores on reverse enable rising edge
// - all paths invert; backplane high means driver released
// - backplane drives only when high enable is high
// - backplane drives only when low enable is low
// - local pins driven only while local enable high
// - floating backplane input reads as high
// - storage keeps working while outputs are released
`timescale 1ns/1ps
module ilbt_top
   import ilbt_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [APB_W-1:0] pwdata_i,
   output logic [APB_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // mode and enables
   input wire logic mode_select_first_i,
   input wire logic mode_select_second_i,
   input wire logic forward_clock_latch_enable_i,
   input wire logic reverse_clock_latch_enable_i,
   input wire logic backplane_enable_high_i,
   input wire logic backplane_enable_low_i,
   input wire logic local_output_enable_i,
   // local port
   input wire logic [DATA_W-1:0] local_data_pins_i,
   output logic [DATA_W-1:0] local_data_pins_o,
   output logic [DATA_W-1:0] local_data_pins_oe_o,
   // backplane port
   input wire logic [DATA_W-1:0] backplane_data_pins_i,
   output logic [DATA_W-1:0] backplane_data_pins_o,
   output logic [DATA_W-1:0] backplane_data_pins_oe_o
);

   logic [CTRL_W-1:0] ctrl_q;
   logic sel_first_w;
   logic sel_second_w;
   logic bp_enable_w;
   ilbt_mode_t fwd_mode_w;
   ilbt_mode_t rev_mode_w;
   logic [DATA_W-1:0] loc_out_q;
   logic [DATA_W-1:0] loc_oe_q;
   logic [DATA_W-1:0] bp_out_q;
   logic [DATA_W-1:0] bp_oe_q;
   logic [CNT_W-1:0] cnt_q [DIR_N];
   logic [APB_W-1:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic apb_setup_w;
   logic apb_access_w;
   logic apb_write_w;
   logic cnt_clr_w;
   logic [APB_W-1:0] rd_data_w;
   logic rd_hit_w;

   ilbt_path_if pif [DIR_N] ();

   // effective selects: pins unless software takes over
   assign sel_first_w = ctrl_q[CTRL_SW_EN_BIT] ? ctrl_q[CTRL_SEL_FIRST_BIT]
                                               : mode_select_first_i;
   assign sel_second_w = ctrl_q[CTRL_SW_EN_BIT] ? ctrl_q[CTRL_SEL_SECOND_BIT]
                                                : mode_select_second_i;

   assign fwd_mode_w = ilbt_fwd_mode(sel_first_w, sel_second_w);
   assign rev_mode_w = ilbt_rev_mode(sel_first_w, sel_second_w);

   assign bp_enable_w = backplane_enable_high_i & ~backplane_enable_low_i;

   assign pif[DIR_FWD].data_in = local_data_pins_i;
   assign pif[DIR_FWD].lcle = forward_clock_latch_enable_i;
   assign pif[DIR_FWD].mode = fwd_mode_w;

   assign pif[DIR_REV].data_in = backplane_data_pins_i;
   assign pif[DIR_REV].lcle = reverse_clock_latch_enable_i;
   assign pif[DIR_REV].mode = rev_mode_w;

   generate
      for (genvar d = 0; d < DIR_N; d++) begin : g_dir
         ilbt_path u_path (
            .clock_i   (clock_i),
            .sys_rst_i (sys_rst_i),
            .pif       (pif[d])
         );

         always_ff @(posedge clock_i) begin
            if (sys_rst_i || cnt_clr_w) begin
               cnt_q[d] <= '0;
            end else if (pif[d].capture) begin
               cnt_q[d] <= cnt_q[d] + CNT_ONE;
            end
         end
      end
   endgenerate

   // local port drive
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         loc_out_q <= DATA_RESET;
         loc_oe_q <= DATA_RESET;
      end else begin
         loc_out_q <= pif[DIR_REV].result;
         loc_oe_q <= {DATA_W{local_output_enable_i}};
      end
   end

   // backplane open-collector drive
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         bp_out_q <= DATA_RESET;
         bp_oe_q <= DATA_RESET;
      end else begin
         bp_out_q <= pif[DIR_FWD].result;
         bp_oe_q <= {DATA_W{bp_enable_w}} & ~pif[DIR_FWD].result;
      end
   end

   // apb phases
   assign apb_setup_w = psel_i & ~penable_i;
   assign apb_access_w = psel_i & penable_i & pready_q;
   assign apb_write_w = apb_access_w & pwrite_i;
   assign cnt_clr_w = apb_write_w & (paddr_i == CTRL_OFS) & pwdata_i[CTRL_CNT_CLR_BIT];

   // read mux and address decode
   always_comb begin
      rd_data_w = APB_ZERO;
      rd_hit_w = 1'b1;
      case (paddr_i)
         CTRL_OFS: begin
            rd_data_w[CTRL_W-1:0] = ctrl_q;
         end
         FWD_OFS: begin
            rd_data_w[DATA_W-1:0] = pif[DIR_FWD].stored;
         end
         REV_OFS: begin
            rd_data_w[DATA_W-1:0] = pif[DIR_REV].stored;
         end
         MODE_OFS: begin
            rd_data_w[MODE_SEL_FIRST_BIT] = sel_first_w;
            rd_data_w[MODE_SEL_SECOND_BIT] = sel_second_w;
            rd_data_w[MODE_FWD_LSB +: 2] = fwd_mode_w;
            rd_data_w[MODE_REV_LSB +: 2] = rev_mode_w;
            rd_data_w[MODE_BP_EN_BIT] = bp_enable_w;
            rd_data_w[MODE_LOC_EN_BIT] = local_output_enable_i;
            rd_data_w[MODE_SW_EN_BIT] = ctrl_q[CTRL_SW_EN_BIT];
         end
         CAPT_OFS: begin
            rd_data_w[CNT_W-1:0] = cnt_q[DIR_FWD];
            rd_data_w[CAPT_REV_LSB +: CNT_W] = cnt_q[DIR_REV];
         end
         default: begin
            rd_hit_w = 1'b0;
         end
      endcase
   end

   // one wait-free access phase: ready in first access cycle
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= APB_ZERO;
      end else if (apb_setup_w) begin
         pready_q <= 1'b1;
         pslverr_q <= ~rd_hit_w;
         prdata_q <= pwrite_i ? APB_ZERO : rd_data_w;
      end else begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= APB_ZERO;
      end
   end

   // control register write
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (apb_write_w && paddr_i == CTRL_OFS) begin
         ctrl_q <= pwdata_i[CTRL_W-1:0];
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign local_data_pins_o = loc_out_q;
   assign local_data_pins_oe_o = loc_oe_q;
   assign backplane_data_pins_o = bp_out_q;
   assign backplane_data_pins_oe_o = bp_oe_q;

endmodule

// ---- ilbt_bp_model.sv ----
/* Far side model: wired-OR backplane with pull-up, and the local pin wire.
   Assumes sink enables high mean a line is pulled low. */
`timescale 1ns/1ps
module ilbt_bp_model
   import ilbt_pkg::*;
(
   // backplane
   input wire logic [DATA_W-1:0] sink_oe_i,
   input wire logic [DATA_W-1:0] other_sink_i,
   output logic [DATA_W-1:0] bp_wire_o,
   // local side
   input wire logic [DATA_W-1:0] loc_drv_i,
   input wire logic [DATA_W-1:0] loc_oe_i,
   input wire logic [DATA_W-1:0] loc_ext_i,
   output logic [DATA_W-1:0] loc_wire_o
);
   assign bp_wire_o = ~(sink_oe_i | other_sink_i);
   assign loc_wire_o = (loc_oe_i & loc_drv_i) | (~loc_oe_i & loc_ext_i);
endmodule

// ---- ilbt_top_sva.sv ----
/* Port checker for the transceiver top.
   Assumes one clock; bound to every ilbt_top. */
`timescale 1ns/1ps
module ilbt_chk
   import ilbt_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // apb answer
   input wire logic pready_o,
   input wire logic pslverr_o,
   // mode and enables
   input wire logic mode_select_first_i,
   input wire logic mode_select_second_i,
   input wire logic forward_clock_latch_enable_i,
   input wire logic reverse_clock_latch_enable_i,
   input wire logic backplane_enable_high_i,
   input wire logic backplane_enable_low_i,
   input wire logic local_output_enable_i,
   // pins
   input wire logic [DATA_W-1:0] local_data_pins_i,
   input wire logic [DATA_W-1:0] local_data_pins_o,
   input wire logic [DATA_W-1:0] local_data_pins_oe_o,
   input wire logic [DATA_W-1:0] backplane_data_pins_i,
   input wire logic [DATA_W-1:0] backplane_data_pins_oe_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   logic [1:0] up_q;
   wire live = up_q == 2'h3;
   wire thru = mode_select_first_i & ~mode_select_second_i;
   wire bpon = backplane_enable_high_i & ~backplane_enable_low_i;
   wire [DATA_W-1:0] loc = local_data_pins_i;
   wire [DATA_W-1:0] boe = backplane_data_pins_oe_o;
   // cycles since reset release
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) up_q <= 2'h0;
      else if (!live) up_q <= up_q + 2'h1;
   end
   property p_fwd_thru;
      (live && thru && bpon && $stable(loc))[*3] |=> boe == $past(loc);
   endproperty
   a_fwd_thru: assert property (p_fwd_thru) else $error("fwd thru");
   property p_fwd_open;
      (live && !mode_select_first_i && !mode_select_second_i && !forward_clock_latch_enable_i
         && bpon && $stable(loc))[*3] |=> boe == $past(loc);
   endproperty
   a_fwd_open: assert property (p_fwd_open) else $error("fwd latch open");
   property p_rev_thru;
      (live && thru && $stable(backplane_data_pins_i))[*3]
         |=> local_data_pins_o == ~$past(backplane_data_pins_i);
   endproperty
   a_rev_thru: assert property (p_rev_thru) else $error("rev thru");
   property p_fwd_hold; (live && !thru && forward_clock_latch_enable_i && bpon)[*5] |-> $stable(boe);
   endproperty
   a_fwd_hold: assert property (p_fwd_hold) else $error("fwd hold");
   property p_rev_hold;
      (live && !thru && reverse_clock_latch_enable_i)[*5] |-> $stable(local_data_pins_o);
   endproperty
   a_rev_hold: assert property (p_rev_hold) else $error("rev hold");
   property p_bp_high; (live && !backplane_enable_high_i)[*3] |-> boe == '0; endproperty
   a_bp_high: assert property (p_bp_high) else $error("bp high enable");
   property p_bp_low; (live && backplane_enable_low_i)[*3] |-> boe == '0; endproperty
   a_bp_low: assert property (p_bp_low) else $error("bp low enable");
   property p_loc_oe; live |-> local_data_pins_oe_o == {DATA_W{$past(local_output_enable_i)}};
   endproperty
   a_loc_oe: assert property (p_loc_oe) else $error("local enable");
   c_fwd_thru: cover property (live && thru && bpon);
   c_rev_hold: cover property (live && !thru && reverse_clock_latch_enable_i);
   c_apb_err: cover property (pready_o && pslverr_o);
endmodule
bind ilbt_top ilbt_chk ilbt_chk_inst (.*);

// ---- tb.sv ----
/* Self-checking bench for the transceiver top.
   Assumes the package, the far side model and the checker are compiled first. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
$display("[ERR] %s exp %h got %h", n, e, g); end end
module tb
   import ilbt_pkg::*;
;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr;
   logic [ADDR_W-1:0] paddr = '0;
   logic [APB_W-1:0] pwdata = '0, prdata;
   logic s1 = 1'b0, s2 = 1'b0, fc = 1'b0, rc = 1'b0, bh = 1'b0, bl = 1'b0, le = 1'b0;
   logic [DATA_W-1:0] lx = '0, sk = '0, lo, loe, bo, boe, bw, lw;
   int errors = 0, num_checks = 0, cycles = 0;
   always #12.5 clock_i = ~clock_i;
   ilbt_top ilbt_top_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .mode_select_first_i(s1),
      .mode_select_second_i(s2), .forward_clock_latch_enable_i(fc),
      .reverse_clock_latch_enable_i(rc), .backplane_enable_high_i(bh),
      .backplane_enable_low_i(bl), .local_output_enable_i(le), .local_data_pins_i(lw),
      .local_data_pins_o(lo), .local_data_pins_oe_o(loe), .backplane_data_pins_i(bw),
      .backplane_data_pins_o(bo), .backplane_data_pins_oe_o(boe));
   ilbt_bp_model ilbt_bp_model_inst (.sink_oe_i(boe), .other_sink_i(sk), .bp_wire_o(bw),
      .loc_drv_i(lo), .loc_oe_i(loe), .loc_ext_i(lx), .loc_wire_o(lw));
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [APB_W-1:0] d,
      input logic [APB_W-1:0] exp, input logic err);
      int t;
      @(posedge clock_i);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      pen <= 1'b1;
      t = 0;
      do begin
         @(posedge clock_i);
         t++;
      end while (pready !== 1'b1);
      `CHK("apb wait", 1, t)
      `CHK("pready", 1'b1, pready)
      if (!wr) `CHK("prdata", exp, prdata)
      `CHK("pslverr", err, pslverr)
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // c = {sel first, sel second, fwd cle, rev cle, bp high, bp low, local oe}
   task automatic pins(input logic [6:0] c, input logic [DATA_W-1:0] x, k);
      @(posedge clock_i);
      {s1, s2, fc, rc, bh, bl, le} <= c;
      lx <= x;
      sk <= k;
      repeat (6) @(posedge clock_i);
      #1;
   endtask
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      repeat (8) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      apb(1'b0, CTRL_OFS, APB_ZERO, APB_ZERO, 1'b0);
      apb(1'b1, CTRL_OFS, 32'h0000_0006, APB_ZERO, 1'b0);
      apb(1'b0, CTRL_OFS, APB_ZERO, 32'h0000_0006, 1'b0);
      apb(1'b1, CTRL_OFS, APB_ZERO, APB_ZERO, 1'b0);
      apb(1'b0, 12'h020, APB_ZERO, APB_ZERO, 1'b1);
      pins(7'b10_00_10_0, 9'h1AA, 9'h000);
      `CHK("fwd thru", 9'h055, bw)
      `CHK("bp out", 9'h055, bo)
      pins(7'b00_00_10_0, 9'h0F0, 9'h000);
      `CHK("fwd open", 9'h10F, bw)
      pins(7'b00_10_10_0, 9'h123, 9'h000);
      `CHK("fwd latched", 9'h10F, bw)
      pins(7'b00_10_00_0, 9'h1C3, 9'h000);
      `CHK("bp released", 9'h1FF, bw)
      pins(7'b00_10_10_0, 9'h1C3, 9'h000);
      `CHK("fwd kept", 9'h10F, bw)
      apb(1'b0, FWD_OFS, APB_ZERO, 32'h0000_00F0, 1'b0);
      pins(7'b01_00_10_0, 9'h1AA, 9'h000);
      pins(7'b01_10_10_0, 9'h000, 9'h000);
      `CHK("fwd reg", 9'h055, bw)
      pins(7'b01_10_11_0, 9'h000, 9'h000);
      `CHK("bp low off", 9'h1FF, bw)
      pins(7'b10_10_00_1, 9'h000, 9'h0F0);
      `CHK("rev thru", 9'h0F0, lw)
      `CHK("loc oe", 9'h1FF, loe)
      pins(7'b11_10_00_1, 9'h000, 9'h05A);
      `CHK("rev open", 9'h05A, lw)
      pins(7'b11_11_00_1, 9'h000, 9'h1A5);
      `CHK("rev latched", 9'h05A, lw)
      pins(7'b11_11_00_0, 9'h000, 9'h1A5);
      `CHK("loc off", 9'h000, loe)
      apb(1'b0, REV_OFS, APB_ZERO, 32'h0000_01A5, 1'b0);
      pins(7'b01_10_00_1, 9'h000, 9'h00F);
      pins(7'b01_11_00_1, 9'h000, 9'h1F0);
      `CHK("rev reg", 9'h00F, lw)
      apb(1'b0, CAPT_OFS, APB_ZERO, 32'h0002_0002, 1'b0);
      apb(1'b1, CTRL_OFS, 32'h0000_0008, APB_ZERO, 1'b0);
      apb(1'b0, CAPT_OFS, APB_ZERO, APB_ZERO, 1'b0);
      pins(7'b00_00_00_1, 9'h000, 9'h0F0);
      `CHK("rev open pins", 9'h0F0, lw)
      apb(1'b1, CTRL_OFS, 32'h0000_0005, APB_ZERO, 1'b0);
      apb(1'b0, MODE_OFS, APB_ZERO, 32'h0000_01BE, 1'b0);
      pins(7'b00_00_00_1, 9'h000, 9'h1AA);
      `CHK("sw register", 9'h0F0, lw)
      conclude();
   end
endmodule
